// [verilog/nfc_host.sv]
`timescale 1ns/10ps
// Overview of operation
// - At most 4 partial programs per page between block erases; code counts per page number over all blocks, any erase clears all.
// - At least 70 ns between last address and first data strobe rise.
// - Each control line changes at most once while write strobe low.
// - Never program or erase a factory bad block; the code refuses only blocks marked bad through mark-bad since reset.
// - Remap logical blocks so invalid blocks are never accessed; code refuses only program and erase on a marked block, reads go out.
// - Only defined commands; during busy only reset and status.
module nfc_host #(
  parameter int PAGE_BYTES = 2112,
  parameter int BLK_BITS = 12
) (
  input wire logic clock,
  input wire logic reset,
  // User port
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [BLK_BITS-1:0] op_block,
  input wire logic [5:0] op_page,
  input wire logic [11:0] op_col,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic op_busy,
  output logic op_done,
  output logic op_refused,
  // Flash pins
  output logic cmd_latch,
  output logic addr_latch,
  output logic chip_sel_n,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic prog_lock_n,
  output logic [7:0] io_out,
  output logic io_oe_n,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  if (BLK_BITS < 1 || BLK_BITS > 16 || PAGE_BYTES < 1 || PAGE_BYTES > 4095) begin : g_geometry
    $error("nfc_host: unsupported geometry");
  end
  typedef enum logic [3:0] {
    NFC_IDLE = 4'h0,
    NFC_CMD1 = 4'h1,
    NFC_ADDR = 4'h2,
    NFC_GAP = 4'h3,
    NFC_DATA = 4'h4,
    NFC_CMD2 = 4'h5,
    NFC_WAITB = 4'h6,
    NFC_BUSY = 4'h7,
    NFC_RDATA = 4'h8,
    NFC_DONE = 4'h9
  } nfc_state_e;
  nfc_state_e state_reg;
  logic [1:0] phase_reg;
  logic [2:0] acnt_reg;
  logic [11:0] bcnt_reg;
  logic [2:0] op_reg;
  logic [39:0] addr_reg;
  logic [7:0] cmd2_reg;
  logic [BLK_BITS-1:0] pblk;
  logic rb_meta_reg;
  logic rb_sync_reg;
  logic [7:0] io_meta_reg;
  logic [7:0] io_sync_reg;
  // Bad-block table and remap table
  logic bad_mem [0:(1<<BLK_BITS)-1];
  logic [BLK_BITS-1:0] map_mem [0:(1<<BLK_BITS)-1];
  logic [2:0] pprog_mem [0:63];
  logic [7:0] cur_byte;
  logic allowed;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clock) begin
    rb_meta_reg <= ready_busy_n;
    rb_sync_reg <= rb_meta_reg;
    io_meta_reg <= io_in;
    io_sync_reg <= io_meta_reg;
  end

  // ==========================================================
  // Block remap; identity until a block is marked bad
  assign pblk = map_mem[op_block];
  always_comb begin
    allowed = 1'b1;
    if ((op_code == nfc_pkg::OP_PROG || op_code == nfc_pkg::OP_ERASE) && bad_mem[pblk])
      allowed = 1'b0;
    if (op_code == nfc_pkg::OP_PROG && pprog_mem[op_page] >= 3'(nfc_pkg::MAX_PARTIAL_PROG))
      allowed = 1'b0;
    if (op_code > nfc_pkg::OP_MARK_BAD)
      allowed = 1'b0;
  end
  // Mark-bad moves the logical block onto the one above; reset forgets all marks
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < (1 << BLK_BITS); i++) begin
        bad_mem[i] <= 1'b0;
        map_mem[i] <= BLK_BITS'(i);
      end
    end else if (state_reg == NFC_IDLE && op_valid && op_code == nfc_pkg::OP_MARK_BAD) begin
      bad_mem[pblk] <= 1'b1;
      map_mem[op_block] <= pblk + 1'b1;
    end
  end
  // Partial-program count per page number; any erase clears them all
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int j = 0; j < 64; j++) pprog_mem[j] <= 3'h0;
    end else if (state_reg == NFC_IDLE && op_valid && allowed) begin
      if (op_code == nfc_pkg::OP_ERASE) begin
        for (int j = 0; j < 64; j++) pprog_mem[j] <= 3'h0;
      end else if (op_code == nfc_pkg::OP_PROG) begin
        pprog_mem[op_page] <= pprog_mem[op_page] + 3'h1;
      end
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    case (state_reg)
      NFC_CMD1: begin
        case (op_reg)
          nfc_pkg::OP_READ: cur_byte = nfc_pkg::CMD_READ_1;
          nfc_pkg::OP_PROG: cur_byte = nfc_pkg::CMD_PROG_1;
          nfc_pkg::OP_ERASE: cur_byte = nfc_pkg::CMD_ERASE_1;
          nfc_pkg::OP_STATUS: cur_byte = nfc_pkg::CMD_STATUS;
          default: cur_byte = nfc_pkg::CMD_RESET;
        endcase
      end
      NFC_ADDR: cur_byte = addr_reg[7:0];
      NFC_DATA: cur_byte = wr_data;
      NFC_CMD2: cur_byte = cmd2_reg;
      default: cur_byte = 8'h00;
    endcase
  end
  // Each write strobe is 4 clocks: setup, low, rise, hold; controls change only in phase 0
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= NFC_IDLE;
      {phase_reg, acnt_reg, bcnt_reg, op_reg, cmd2_reg} <= 28'h0000000;
      addr_reg <= 40'h0;
      {cmd_latch, addr_latch, io_out, rd_data} <= 18'h00000;
      {chip_sel_n, write_strobe_n, output_strobe_n, io_oe_n} <= 4'hF;
      prog_lock_n <= 1'b0;
      {wr_take, rd_valid, op_busy, op_done, op_refused} <= 5'h00;
    end else begin
      {wr_take, rd_valid, op_done, op_refused} <= 4'h0;
      case (state_reg)
        NFC_IDLE: begin
          chip_sel_n <= 1'b1;
          io_oe_n <= 1'b1;
          prog_lock_n <= 1'b0;
          if (op_valid && op_code != nfc_pkg::OP_MARK_BAD) begin
            if (!allowed) begin
              op_refused <= 1'b1;
            end else begin
              op_reg <= op_code;
              op_busy <= 1'b1;
              // Row is block over page; erase sends the three row bytes only
              addr_reg <= (op_code == nfc_pkg::OP_ERASE) ? {16'h0000, 24'({pblk, 6'h00})} :
                {24'({pblk, op_page}), 4'h0, op_col};
              prog_lock_n <= (op_code == nfc_pkg::OP_PROG || op_code == nfc_pkg::OP_ERASE);
              cmd2_reg <= (op_code == nfc_pkg::OP_READ) ? nfc_pkg::CMD_READ_2 :
                (op_code == nfc_pkg::OP_PROG) ? nfc_pkg::CMD_PROG_2 : nfc_pkg::CMD_ERASE_2;
              acnt_reg <= (op_code == nfc_pkg::OP_ERASE) ? 3'h3 : 3'(nfc_pkg::ADDR_CYCLES);
              bcnt_reg <= 12'(PAGE_BYTES) - op_col;
              phase_reg <= 2'h0;
              state_reg <= NFC_CMD1;
            end
          end
        end
        NFC_CMD1, NFC_ADDR, NFC_DATA, NFC_CMD2: begin
          phase_reg <= phase_reg + 2'h1;
          case (phase_reg)
            2'h0: begin
              chip_sel_n <= 1'b0;
              cmd_latch <= (state_reg == NFC_CMD1 || state_reg == NFC_CMD2);
              addr_latch <= (state_reg == NFC_ADDR);
              io_out <= cur_byte;
              io_oe_n <= 1'b0;
              if (state_reg == NFC_DATA) wr_take <= 1'b1;
            end
            2'h1: write_strobe_n <= 1'b0;
            2'h2: write_strobe_n <= 1'b1;
            default: begin
              if (state_reg == NFC_CMD1) begin
                if (op_reg == nfc_pkg::OP_STATUS)
                  state_reg <= NFC_RDATA;
                else if (op_reg == nfc_pkg::OP_RESET)
                  state_reg <= NFC_WAITB;
                else
                  state_reg <= NFC_ADDR;
              end else if (state_reg == NFC_ADDR) begin
                addr_reg <= {8'h00, addr_reg[39:8]};
                acnt_reg <= acnt_reg - 3'h1;
                if (acnt_reg == 3'h1)
                  state_reg <= (op_reg == nfc_pkg::OP_PROG) ? NFC_GAP : NFC_CMD2;
              end else if (state_reg == NFC_DATA) begin
                bcnt_reg <= bcnt_reg - 12'h001;
                if (bcnt_reg == 12'h001) state_reg <= NFC_CMD2;
              end else begin
                state_reg <= NFC_WAITB;
              end
            end
          endcase
        end
        NFC_GAP: begin
          // Data strobe rises 4 clocks later, well over the gap
          if (acnt_reg >= 3'(nfc_pkg::ADDR_TO_DATA_GAP_CYC) - 3'h1)
            state_reg <= NFC_DATA;
          acnt_reg <= acnt_reg + 3'h1;
          phase_reg <= 2'h0;
        end
        NFC_WAITB: begin
          // Device may take one strobe-to-busy time to drop ready
          io_oe_n <= 1'b1;
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'(nfc_pkg::WB_CYC)) begin
            phase_reg <= 2'h0;
            state_reg <= NFC_BUSY;
          end
        end
        NFC_BUSY: begin
          // Nothing issued while busy; status polling would go here
          if (rb_sync_reg) begin
            if (op_reg == nfc_pkg::OP_READ) state_reg <= NFC_RDATA;
            else state_reg <= NFC_DONE;
          end
        end
        NFC_RDATA: begin
          cmd_latch <= 1'b0;
          addr_latch <= 1'b0;
          io_oe_n <= 1'b1;
          phase_reg <= phase_reg + 2'h1;
          case (phase_reg)
            2'h0: output_strobe_n <= 1'b0;
            2'h1, 2'h2: ;
            default: begin
              // Two synchroniser stages: the pin byte settles in io_sync_reg only now
              rd_data <= io_sync_reg;
              rd_valid <= 1'b1;
              output_strobe_n <= 1'b1;
              bcnt_reg <= bcnt_reg - 12'h001;
              if (op_reg == nfc_pkg::OP_STATUS || bcnt_reg == 12'h001)
                state_reg <= NFC_DONE;
            end
          endcase
        end
        NFC_DONE: begin
          chip_sel_n <= 1'b1;
          prog_lock_n <= 1'b0;
          op_busy <= 1'b0;
          op_done <= 1'b1;
          state_reg <= NFC_IDLE;
        end
        default: state_reg <= NFC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  sequence addr_last_s;
    state_reg == NFC_ADDR && phase_reg == 2'h3 && acnt_reg == 3'h1 && op_reg == nfc_pkg::OP_PROG;
  endsequence

  addr_gap_a: assert property (@(posedge clock) disable iff (reset)
    addr_last_s |=> !write_strobe_n == 1'b0 [*3]) else $error("address to data gap short");
  ctl_stable_a: assert property (@(posedge clock) disable iff (reset)
    !write_strobe_n |=> $stable(cmd_latch) && $stable(addr_latch) && $stable(chip_sel_n))
    else $error("control moved under strobe");
  cmd_addr_a: assert property (@(posedge clock) disable iff (reset)
    !write_strobe_n |-> !(cmd_latch && addr_latch)) else $error("both latches high");
  busy_quiet_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == NFC_BUSY |-> write_strobe_n && output_strobe_n) else $error("strobe during busy");
  lock_idle_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == NFC_DONE |=> !prog_lock_n && chip_sel_n) else $error("lock not restored");
  bad_block_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == NFC_IDLE && op_valid && op_code == nfc_pkg::OP_ERASE && bad_mem[pblk]
    |=> op_refused && state_reg == NFC_IDLE) else $error("bad block accessed");
  pprog_lim_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == NFC_IDLE && op_valid && op_code == nfc_pkg::OP_PROG &&
    pprog_mem[op_page] >= 3'h4 |=> op_refused) else $error("partial program limit");
  remap_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == NFC_IDLE && op_valid && allowed && op_code == nfc_pkg::OP_ERASE
    |=> addr_reg[BLK_BITS+5:6] == $past(pblk)) else $error("remap not applied");
endmodule : nfc_host

// [verilog/nfc_pkg.sv]
package nfc_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_1 = 8'h00;
  localparam logic [7:0] CMD_READ_2 = 8'h30;
  localparam logic [7:0] CMD_PROG_1 = 8'h80;
  localparam logic [7:0] CMD_PROG_2 = 8'h10;
  localparam logic [7:0] CMD_ERASE_1 = 8'h60;
  localparam logic [7:0] CMD_ERASE_2 = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  // Operation codes on the user port
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_STATUS = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam logic [2:0] OP_MARK_BAD = 3'h5;
  // Timing
  localparam int CLOCK_NS = 100;
  localparam int ADDR_TO_DATA_GAP_NS = 70;
  localparam int ADDR_TO_DATA_GAP_CYC = (ADDR_TO_DATA_GAP_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int WB_NS = 100;
  localparam int WB_CYC = (WB_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int ADDR_CYCLES = 5;
  localparam int MAX_PARTIAL_PROG = 4;
  localparam int BLOCK_COUNT = 4096;
endpackage : nfc_pkg

// [tb/nfc_flash_model.sv]
`timescale 1ns/10ps
// ==========================================================
// Flash device model
// Busy times are shortened so that runs stay short; all are within the limits.
module nfc_flash_model #(
  parameter int FETCH_NS = 2000,
  parameter int PROG_NS = 3000,
  parameter int ERASE_NS = 4000,
  parameter int RESET_NS = 1000,
  parameter int BAD_BLOCK = 3,
  parameter logic [7:0] STATUS_READY = 8'hE0
) (
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic chip_sel_n,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic prog_lock_n,
  input wire logic [7:0] io_out,
  output logic [7:0] io_in,
  output logic ready_busy_n,
  output logic [7:0] viol_count,
  output logic [23:0] last_row
);
  logic [7:0] mem [int];
  int nop [int];
  logic [7:0] addr_b [5];
  logic [7:0] last_cmd = 8'h00;
  int n_addr = 0;
  int col = 0;
  int viols = 0;
  int ch [3];
  realtime t_addr = 0;
  logic data_seen = 1'b1;

  assign viol_count = 8'(viols);
  initial begin
    io_in = 8'h00;
    ready_busy_n = 1'b1;
    last_row = 24'h000000;
  end

  task automatic busy_for(input int ns);
    fork
      begin
        ready_busy_n = 1'b0;
        #(ns);
        ready_busy_n = 1'b1;
      end
    join_none
  endtask : busy_for

  always @(posedge write_strobe_n) begin
    int r;
    r = int'({addr_b[4], addr_b[3], addr_b[2]});
    if (chip_sel_n === 1'b0 && cmd_latch && !addr_latch) begin
      if (!ready_busy_n && io_out != 8'hFF && io_out != 8'h70) viols++;
      last_cmd = io_out;
      case (io_out)
        8'h00, 8'h80: begin
          n_addr = 0;
          data_seen = (io_out == 8'h00);
        end
        8'h60: n_addr = 2;
        8'h30: busy_for(FETCH_NS);
        8'h10: if (prog_lock_n) begin
          last_row = 24'(r);
          nop[r] = nop.exists(r) ? nop[r] + 1 : 1;
          if (nop[r] > 4) viols++;
          if (r / 64 == BAD_BLOCK) viols++;
          busy_for(PROG_NS);
        end
        8'hD0: if (prog_lock_n) begin
          last_row = 24'(r);
          foreach (nop[i]) if (i / 64 == r / 64) nop[i] = 0;
          if (r / 64 == BAD_BLOCK) viols++;
          busy_for(ERASE_NS);
        end
        8'hFF: busy_for(RESET_NS);
        default: ;
      endcase
    end else if (chip_sel_n === 1'b0 && addr_latch && !cmd_latch) begin
      if (n_addr < 5) addr_b[n_addr] = io_out;
      n_addr++;
      t_addr = $realtime;
      col = int'({addr_b[1][3:0], addr_b[0]});
    end else if (chip_sel_n === 1'b0 && !addr_latch && !cmd_latch) begin
      if (!data_seen && $realtime - t_addr < 70.0) viols++;
      data_seen = 1'b1;
      if (prog_lock_n) mem[r * 4096 + col] = io_out;
      col++;
    end
  end

  // Released bus shows the inverse, so a stale sample cannot look right
  always @(negedge output_strobe_n) begin
    int k;
    k = int'({addr_b[4], addr_b[3], addr_b[2]}) * 4096 + col;
    if (chip_sel_n === 1'b0) begin
      io_in = (last_cmd == 8'h70) ? STATUS_READY : (mem.exists(k) ? mem[k] : 8'hFF);
    end
  end
  always @(posedge output_strobe_n) begin
    io_in = ~io_in;
    if (last_cmd != 8'h70) col++;
  end

  always @(negedge write_strobe_n) ch = '{0, 0, 0};
  always @(cmd_latch) if (write_strobe_n === 1'b0 && ++ch[0] > 1) viols++;
  always @(addr_latch) if (write_strobe_n === 1'b0 && ++ch[1] > 1) viols++;
  always @(chip_sel_n) if (write_strobe_n === 1'b0 && ++ch[2] > 1) viols++;
endmodule : nfc_flash_model

// [tb/nfc_host_test.sv]
`timescale 1ns/10ps
module nfc_host_test;
  localparam int PB = 8;
  logic clock, reset, op_valid;
  logic [2:0] op_code;
  logic [11:0] op_block, op_col;
  logic [5:0] op_page;
  logic [7:0] wr_data, rd_data, io_out, io_in, viol_count;
  logic [23:0] last_row;
  logic wr_take, rd_valid, op_busy, op_done, op_refused, cmd_latch, addr_latch, chip_sel_n;
  logic write_strobe_n, output_strobe_n, prog_lock_n, io_oe_n, ready_busy_n, done, refused;
  logic [7:0] rd_q [$];
  int wcnt, miscompares = 0, tests_run = 0;

  nfc_host #(.PAGE_BYTES(PB), .BLK_BITS(12)) u_dut (.clock(clock), .reset(reset),
    .op_valid(op_valid), .op_code(op_code), .op_block(op_block), .op_page(op_page),
    .op_col(op_col), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .op_busy(op_busy), .op_done(op_done), .op_refused(op_refused),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch), .chip_sel_n(chip_sel_n),
    .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
    .prog_lock_n(prog_lock_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  nfc_flash_model u_flash (.cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .prog_lock_n(prog_lock_n), .io_out(io_out),
    .io_in(io_in), .ready_busy_n(ready_busy_n), .viol_count(viol_count), .last_row(last_row));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // ==========================================================
  // One user request, then collect bytes until done or refused; mark-bad returns at once
  task automatic run_op(input logic [2:0] code, input int blk, input int pg, input int col,
                        input logic [7:0] b);
    @(negedge clock);
    {op_valid, op_code, op_block, op_page, op_col} = {1'b1, code, 12'(blk), 6'(pg), 12'(col)};
    {wcnt, done, refused, wr_data} = {32'd0, 1'b0, 1'b0, b};
    rd_q.delete();
    @(negedge clock);
    op_valid = 1'b0;
    if (code == nfc_pkg::OP_MARK_BAD) return;
    for (int n = 0; n < 5000 && !done && !refused; n++) begin
      // The byte is taken at the edge that raises wr_take; offer the next one
      if (wr_take === 1'b1) begin
        wcnt++;
        wr_data = b + 8'(wcnt);
      end
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      done = (op_done === 1'b1);
      refused = (op_refused === 1'b1);
      if (!done && !refused) @(negedge clock);
    end
  endtask : run_op

  task automatic t_reset_state();
    check({chip_sel_n, write_strobe_n, output_strobe_n, io_oe_n}, 4'hF, "idle pins");
    check({prog_lock_n, op_busy}, 2'h0, "lock and busy");
  endtask : t_reset_state

  task automatic t_prog_read();
    run_op(nfc_pkg::OP_PROG, 1, 2, 4, 8'h40);
    check(done, 1'b1, "program done");
    check(wcnt, PB - 4, "bytes taken");
    check(last_row, 24'd66, "program row");
    run_op(nfc_pkg::OP_READ, 1, 2, 4, 8'h00);
    check(done, 1'b1, "read done");
    check(rd_q.size(), PB - 4, "read count");
    foreach (rd_q[i]) check(rd_q[i], 8'h40 + 8'(i), "read byte");
  endtask : t_prog_read

  task automatic t_partial();
    for (int i = 2; i <= 5; i++) begin
      run_op(nfc_pkg::OP_PROG, 1, 2, 6, 8'h10);
      check({done, refused}, (i < 5) ? 2'b10 : 2'b01, "partial program");
    end
    run_op(nfc_pkg::OP_ERASE, 1, 0, 0, 8'h00);
    check(done, 1'b1, "erase done");
    check(last_row[23:6], 18'd1, "erase block");
    run_op(nfc_pkg::OP_PROG, 1, 2, 6, 8'h10);
    check(done, 1'b1, "program after erase");
    run_op(nfc_pkg::OP_ERASE, 0, 0, 0, 8'h00);
    check({done, last_row}, {1'b1, 24'd0}, "block zero erase");
  endtask : t_partial

  task automatic t_bad_block();
    run_op(nfc_pkg::OP_MARK_BAD, 3, 0, 0, 8'h00);
    run_op(nfc_pkg::OP_PROG, 3, 1, 0, 8'h20);
    check(done, 1'b1, "remapped program");
    check(last_row, 24'd257, "remapped row");
    // Logical 3 now lands on physical 4; marking 4 bad makes that target bad
    run_op(nfc_pkg::OP_MARK_BAD, 4, 0, 0, 8'h00);
    run_op(nfc_pkg::OP_ERASE, 3, 0, 0, 8'h00);
    check({done, refused}, 2'b01, "erase onto bad block");
  endtask : t_bad_block

  task automatic t_status_reset_codes();
    run_op(nfc_pkg::OP_STATUS, 0, 0, 0, 8'h00);
    check(done, 1'b1, "status done");
    check(rd_q.size() > 0 ? rd_q[0] : 8'h00, 8'hE0, "status byte");
    run_op(nfc_pkg::OP_RESET, 0, 0, 0, 8'h00);
    check(done, 1'b1, "reset done");
    for (int c = 6; c < 8; c++) begin
      run_op(3'(c), 0, 0, 0, 8'h00);
      check({done, refused}, 2'b01, "unknown code");
    end
  endtask : t_status_reset_codes

  initial begin
    {reset, op_valid, op_code, op_block, op_page, op_col, wr_data} = {1'b1, 42'd0};
    repeat (5) @(negedge clock);
    reset = 1'b0;
    t_reset_state();
    t_prog_read();
    t_partial();
    t_bad_block();
    t_status_reset_codes();
    check(viol_count, 8'h00, "device side faults");
    summarize();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    #2_000_000;
    miscompares++;
    summarize();
  end
endmodule : nfc_host_test
